//--- src/cocr_pkg.sv
`default_nettype none
package cocr_pkg;
	localparam int         NREG = 9;
	localparam int         IX_PLL2 = 0;
	localparam int         IX_OEC = 1;
	localparam int         IX_PFS = 2;
	localparam int         IX_LOOP = 3;
	localparam int         IX_WDG = 4;
	localparam int         IX_POL = 5;
	localparam int         IX_D1 = 6;
	localparam int         IX_D2 = 7;
	localparam int         IX_SE = 8;
	// index order 8 down to 0
	localparam logic [NREG-1:0][7:0] REG_OFS =
		{8'h24, 8'h23, 8'h22, 8'h21, 8'h20, 8'h1f, 8'h1e, 8'h1d, 8'h18};
	localparam logic [NREG-1:0][7:0] REG_RST =
		{8'h8c, 8'h34, 8'hf4, 8'ha0, 8'h00, 8'h04, 8'h80, 8'h33, 8'h0e};
	localparam logic [NREG-1:0][7:0] REG_WMSK =
		{8'hdf, 8'hb3, 8'hb3, 8'h07, 8'h1e, 8'h0e, 8'he3, 8'hff, 8'hff};
	localparam int         B_SPREAD = 5;
	localparam int         B_D1_GATE = 7;
	localparam int         B_D2_GATE = 6;
	localparam int         B_D1_EN = 5;
	localparam int         B_D2_EN = 4;
	localparam int         B_DIV4_SRC = 3;
	localparam int         B_SINGLE_OUT1_ENABLE = 7;
	localparam int         F_ROLE_LO = 5;
	localparam int         F_FSEL_LO = 0;
	localparam int         B_CH2 = 2;
	localparam int         B_FREQ_SWITCH_ENABLE = 4;
	localparam int         B_WATCHDOG_ENABLE = 3;
	localparam int         F_TSEL_LO = 1;
	localparam int         B_ALARM = 0;
	localparam int         B_HIZ = 2;
	localparam int         B_D1_POL = 1;
	localparam int         B_D2_POL = 0;
	localparam int         B_CLKSEL = 7;
	localparam int         F_TYPE_LO = 4;
	localparam int         B_BPIN = 0;
	localparam int         B_RUN = 7;
	localparam int         B_SE1_DEF = 4;
	localparam int         B_SE1_CSEL = 3;
	localparam int         B_CH3D4 = 1;
	localparam int         B_CH2D4 = 0;
	localparam logic [1:0] TYPE_CMOS = 2'b00;
	localparam logic [1:0] TYPE_HCSL = 2'b11;
	// arbitrary bus address
	localparam logic [6:0] I2C_DEV_ADDR = 7'h6a;
	localparam int         CLK_NS = 100;
	localparam int         WDT_MS0 = 250;
	localparam int         WDT_MS1 = 500;
	localparam int         WDT_MS2 = 2000;
	localparam int         WDT_MS3 = 4000;
	localparam int         WDT_CYC0 = WDT_MS0 * (1000000 / CLK_NS);
	localparam int         WDT_CYC1 = WDT_MS1 * (1000000 / CLK_NS);
	localparam int         WDT_CYC2 = WDT_MS2 * (1000000 / CLK_NS);
	localparam int         WDT_CYC3 = WDT_MS3 * (1000000 / CLK_NS);
	localparam int         WD_W = 26;
	typedef enum logic [1:0] {
		ROLE_SE1_OE = 2'b00,
		ROLE_PD_N   = 2'b01,
		ROLE_PSAVE  = 2'b10,
		ROLE_FSEL0  = 2'b11
	} cocr_role_e;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_AACK = 3'b011,
		ST_WR   = 3'b010,
		ST_WACK = 3'b110,
		ST_RD   = 3'b111,
		ST_RACK = 3'b101
	} cocr_i2c_e;
endpackage
`default_nettype wire

//--- src/cocr_i2c_slave.sv
`timescale 1ns/100ps
`default_nettype none
module cocr_i2c_slave import cocr_pkg::*; (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	output logic            o_sda_oe_n,
	output logic            o_wr_stb,
	output logic [7:0]      o_ptr,
	output logic [7:0]      o_wr_data,
	input  wire logic [7:0] i_rd_data
);
	logic       scl_m_ff, scl_s_ff, scl_p_ff;
	logic       sda_m_ff, sda_s_ff, sda_p_ff;
	cocr_i2c_e  state_ff;
	logic [2:0] cnt_ff;
	logic [7:0] sh_ff;
	logic       rw_ff, first_ff, done_ff;
	logic       start, stop, rise, fall;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			{scl_m_ff, scl_s_ff, scl_p_ff} <= 3'h7;
			{sda_m_ff, sda_s_ff, sda_p_ff} <= 3'h7;
		end else begin
			{scl_m_ff, scl_s_ff, scl_p_ff} <= {i_scl, scl_m_ff, scl_s_ff};
			{sda_m_ff, sda_s_ff, sda_p_ff} <= {i_sda, sda_m_ff, sda_s_ff};
		end
	end

	assign start = scl_s_ff & scl_p_ff & sda_p_ff & ~sda_s_ff;
	assign stop  = scl_s_ff & scl_p_ff & ~sda_p_ff & sda_s_ff;
	assign rise  = scl_s_ff & ~scl_p_ff;
	assign fall  = ~scl_s_ff & scl_p_ff;

	////////////////////////////////////////////////////////////////
	// sda only changes after a falling scl, so setup is a half bit
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 3'h0;
			sh_ff <= 8'h00;
			rw_ff <= 1'b0;
			first_ff <= 1'b1;
			done_ff <= 1'b0;
			o_sda_oe_n <= 1'b1;
			o_wr_stb <= 1'b0;
			o_ptr <= 8'h00;
			o_wr_data <= 8'h00;
		end else begin
			o_wr_stb <= 1'b0;
			if (start) begin
				state_ff <= ST_ADDR;
				cnt_ff <= 3'h0;
				done_ff <= 1'b0;
				first_ff <= 1'b1;
				o_sda_oe_n <= 1'b1;
			end else if (stop) begin
				state_ff <= ST_IDLE;
				o_sda_oe_n <= 1'b1;
			end else begin
				case (state_ff)
					ST_ADDR, ST_WR: begin
						if (rise) begin
							sh_ff <= {sh_ff[6:0], sda_s_ff};
							cnt_ff <= cnt_ff + 3'h1;
							done_ff <= (cnt_ff == 3'h7);
						end else if (fall && done_ff) begin
							done_ff <= 1'b0;
							if (state_ff == ST_ADDR) begin
								if (sh_ff[7:1] == I2C_DEV_ADDR) begin
									rw_ff <= sh_ff[0];
									o_sda_oe_n <= 1'b0;
									state_ff <= ST_AACK;
								end else begin
									state_ff <= ST_IDLE;
								end
							end else begin
								o_sda_oe_n <= 1'b0;
								state_ff <= ST_WACK;
								if (first_ff) begin
									o_ptr <= sh_ff;
								end else begin
									o_wr_stb <= 1'b1;
									o_wr_data <= sh_ff;
								end
							end
						end
					end
					ST_AACK, ST_WACK: begin
						if (fall) begin
							cnt_ff <= 3'h0;
							if (state_ff == ST_AACK && rw_ff) begin
								sh_ff <= i_rd_data;
								o_sda_oe_n <= i_rd_data[7];
								o_ptr <= o_ptr + 8'h01;
								state_ff <= ST_RD;
							end else begin
								o_sda_oe_n <= 1'b1;
								state_ff <= ST_WR;
								if (state_ff == ST_WACK && first_ff) begin
									first_ff <= 1'b0;
								end else if (state_ff == ST_WACK) begin
									o_ptr <= o_ptr + 8'h01;
								end
							end
						end
					end
					ST_RD: begin
						if (rise) begin
							cnt_ff <= cnt_ff + 3'h1;
							done_ff <= (cnt_ff == 3'h7);
						end else if (fall && done_ff) begin
							done_ff <= 1'b0;
							o_sda_oe_n <= 1'b1;
							state_ff <= ST_RACK;
						end else if (fall) begin
							sh_ff <= {sh_ff[6:0], 1'b0};
							o_sda_oe_n <= sh_ff[6];
						end
					end
					ST_RACK: begin
						if (rise) begin
							done_ff <= ~sda_s_ff;
						end else if (fall && done_ff) begin
							done_ff <= 1'b0;
							cnt_ff <= 3'h0;
							sh_ff <= i_rd_data;
							o_sda_oe_n <= i_rd_data[7];
							o_ptr <= o_ptr + 8'h01;
							state_ff <= ST_RD;
						end else if (fall) begin
							state_ff <= ST_IDLE;
						end
					end
					default: state_ff <= ST_IDLE;
				endcase
			end
		end
	end
endmodule // cocr_i2c_slave
`default_nettype wire

//--- src/cocr_top.sv
`timescale 1ns/100ps
`default_nettype none
module cocr_top import cocr_pkg::*; #(
	parameter int P_WDT_CYC0 = WDT_CYC0,
	parameter int P_WDT_CYC1 = WDT_CYC1,
	parameter int P_WDT_CYC2 = WDT_CYC2,
	parameter int P_WDT_CYC3 = WDT_CYC3
) (
	input  wire logic I_CLOCK,
	input  wire logic I_RST_N,
	input  wire logic I_SCL,
	input  wire logic I_SDA,
	output logic      O_SDA_O,
	output logic      O_SDA_OE_N,
	input  wire logic I_CTRL_PIN1,
	input  wire logic I_OE2_PIN,
	output logic      O_CHIP_PD,
	output logic      O_DIFF_HIZ,
	output logic      O_DIFFOUT1_ENABLE,
	output logic      O_DIFFOUT2_ENABLE,
	output logic      O_DIFF1_SRC,
	output logic      O_DIFF2_SRC,
	output logic      O_DIFF1_HCSL,
	output logic      O_DIFF2_HCSL,
	output logic      O_DIFF1_B_EN,
	output logic      O_DIFF2_B_EN,
	output logic      O_DIFF1_B_INV,
	output logic      O_DIFF2_B_INV,
	output logic      O_DIV4_SRC,
	output logic      O_DIVIDER4_CHAN2_ENABLE,
	output logic      O_DIVIDER4_CHAN3_ENABLE,
	output logic      O_PLL2_CH2_EN,
	output logic      O_PLL2_SPREAD_EN,
	output logic      O_SINGLE_OUT1_ENABLE,
	output logic      O_SE1_LOWFREQ,
	output logic      O_SE1_DIV4,
	output logic      O_SE1_PWR_SAVE,
	output logic      O_FREQ_SW_EN,
	output logic [1:0] O_FREQ_SEL,
	output logic      O_WD_ALARM
);
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (!I_RST_N);

	function automatic logic [4:0] reg_lookup(input logic [7:0] a);
		logic [4:0] r;
		r = 5'h00;
		for (int k = 0; k < NREG; k++) begin
			if (REG_OFS[k] == a) begin
				r = {1'b1, 4'(k)};
			end
		end
		return r;
	endfunction

	logic [7:0]    regs_ff [NREG];
	logic          wr_stb;
	logic [7:0]    ptr, wr_data, rd_data;
	logic          wr_hit, rd_hit;
	logic [3:0]    wr_ix, rd_ix;
	logic [1:0]    pin_m_ff, pin_s_ff;
	logic          pin1_s, oe2_s;
	logic [WD_W-1:0] wd_cnt_ff, wd_lim;
	logic          alarm_ff, wd_fire, alarm_clr;
	cocr_role_e    role;
	logic          pd, se1_gate;
	logic [1:0]    d1_type, d2_type;
	logic          d1_on, d2_on;

	cocr_i2c_slave cocr_i2c_slave_i (
		.i_clk      (I_CLOCK),
		.i_rst_n    (I_RST_N),
		.i_scl      (I_SCL),
		.i_sda      (I_SDA),
		.o_sda_oe_n (O_SDA_OE_N),
		.o_wr_stb   (wr_stb),
		.o_ptr      (ptr),
		.o_wr_data  (wr_data),
		.i_rd_data  (rd_data)
	);
	// open drain: only ever pulls low
	assign O_SDA_O = 1'b0;

	////////////////////////////////////////////////////////////////
	// pins from outside the clock domain
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_N) begin
			pin_m_ff <= 2'h3;
			pin_s_ff <= 2'h3;
		end else begin
			pin_m_ff <= {I_OE2_PIN, I_CTRL_PIN1};
			pin_s_ff <= pin_m_ff;
		end
	end
	assign pin1_s = pin_s_ff[0];
	assign oe2_s = pin_s_ff[1];

	////////////////////////////////////////////////////////////////
	// register bank
	assign {wr_hit, wr_ix} = reg_lookup(ptr);
	assign {rd_hit, rd_ix} = reg_lookup(ptr);

	for (genvar g = 0; g < NREG; g++) begin : g_reg
		always_ff @(posedge I_CLOCK) begin
			if (!I_RST_N) begin
				regs_ff[g] <= REG_RST[g];
			end else if (wr_stb && wr_hit && wr_ix == 4'(g)) begin
				regs_ff[g] <= (regs_ff[g] & ~REG_WMSK[g]) | (wr_data & REG_WMSK[g]);
			end
		end
	end

	// alarm is merged on read, never stored from the bus
	always_comb begin
		rd_data = 8'h00;
		if (rd_hit) begin
			rd_data = regs_ff[rd_ix];
			if (rd_ix == 4'(IX_WDG)) begin
				rd_data[B_ALARM] = alarm_ff;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// watchdog: any register write services it
	always_comb begin
		case (regs_ff[IX_WDG][F_TSEL_LO +: 2])
			2'b00: wd_lim = WD_W'(P_WDT_CYC0 - 1);
			2'b01: wd_lim = WD_W'(P_WDT_CYC1 - 1);
			2'b10: wd_lim = WD_W'(P_WDT_CYC2 - 1);
			default: wd_lim = WD_W'(P_WDT_CYC3 - 1);
		endcase
	end

	assign wd_fire = regs_ff[IX_WDG][B_WATCHDOG_ENABLE] && !wr_stb && wd_cnt_ff == wd_lim;
	assign alarm_clr = wr_stb && wr_hit && wr_ix == 4'(IX_WDG) && !wr_data[B_WATCHDOG_ENABLE];

	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_N) begin
			wd_cnt_ff <= '0;
		end else if (!regs_ff[IX_WDG][B_WATCHDOG_ENABLE] || wr_stb) begin
			wd_cnt_ff <= '0;
		end else if (wd_cnt_ff < wd_lim) begin
			wd_cnt_ff <= wd_cnt_ff + 1'b1;
		end
	end

	// set beats clear; cleared only by writing the watchdog off
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_N) begin
			alarm_ff <= 1'b0;
		end else if (wd_fire) begin
			alarm_ff <= 1'b1;
		end else if (alarm_clr) begin
			alarm_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// output decode
	assign role = cocr_role_e'(regs_ff[IX_PFS][F_ROLE_LO +: 2]);
	assign pd = !regs_ff[IX_SE][B_RUN] || (role == ROLE_PD_N && !pin1_s);
	assign se1_gate = (role == ROLE_SE1_OE || role == ROLE_PSAVE) ? pin1_s : 1'b1;
	assign d1_type = regs_ff[IX_D1][F_TYPE_LO +: 2];
	assign d2_type = regs_ff[IX_D2][F_TYPE_LO +: 2];
	// reserved type codes leave the output off
	assign d1_on = regs_ff[IX_OEC][B_D1_EN] && !pd && (d1_type == TYPE_CMOS || d1_type == TYPE_HCSL)
		&& (!regs_ff[IX_OEC][B_D1_GATE] || oe2_s);
	assign d2_on = regs_ff[IX_OEC][B_D2_EN] && !pd && (d2_type == TYPE_CMOS || d2_type == TYPE_HCSL)
		&& (!regs_ff[IX_OEC][B_D2_GATE] || oe2_s);

	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_N) begin
			O_CHIP_PD <= 1'b0;
			O_DIFF_HIZ <= 1'b0;
			O_DIFFOUT1_ENABLE <= 1'b0;
			O_DIFFOUT2_ENABLE <= 1'b0;
			O_DIFF1_HCSL <= 1'b0;
			O_DIFF2_HCSL <= 1'b0;
			O_DIFF1_B_EN <= 1'b0;
			O_DIFF2_B_EN <= 1'b0;
			O_SINGLE_OUT1_ENABLE <= 1'b0;
			O_SE1_PWR_SAVE <= 1'b0;
		end else begin
			O_CHIP_PD <= pd;
			O_DIFF_HIZ <= pd && regs_ff[IX_POL][B_HIZ];
			O_DIFFOUT1_ENABLE <= d1_on;
			O_DIFFOUT2_ENABLE <= d2_on;
			O_DIFF1_HCSL <= d1_on && d1_type == TYPE_HCSL;
			O_DIFF2_HCSL <= d2_on && d2_type == TYPE_HCSL;
			O_DIFF1_B_EN <= d1_on && d1_type == TYPE_CMOS && regs_ff[IX_D1][B_BPIN];
			O_DIFF2_B_EN <= d2_on && d2_type == TYPE_CMOS && regs_ff[IX_D2][B_BPIN];
			O_SINGLE_OUT1_ENABLE <= regs_ff[IX_PFS][B_SINGLE_OUT1_ENABLE] && !pd && se1_gate;
			O_SE1_PWR_SAVE <= role == ROLE_PSAVE && !pin1_s && !pd;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_N) begin
			O_DIFF1_SRC <= 1'b0;
			O_DIFF2_SRC <= 1'b0;
			O_DIFF1_B_INV <= 1'b0;
			O_DIFF2_B_INV <= 1'b0;
			O_DIV4_SRC <= 1'b0;
			O_DIVIDER4_CHAN2_ENABLE <= 1'b0;
			O_DIVIDER4_CHAN3_ENABLE <= 1'b0;
			O_PLL2_CH2_EN <= 1'b0;
			O_PLL2_SPREAD_EN <= 1'b0;
			O_SE1_LOWFREQ <= 1'b0;
			O_SE1_DIV4 <= 1'b0;
			O_FREQ_SW_EN <= 1'b0;
			O_FREQ_SEL <= 2'h0;
			O_WD_ALARM <= 1'b0;
		end else begin
			O_DIFF1_SRC <= regs_ff[IX_D1][B_CLKSEL];
			O_DIFF2_SRC <= regs_ff[IX_D2][B_CLKSEL];
			O_DIFF1_B_INV <= d1_type == TYPE_CMOS && !regs_ff[IX_POL][B_D1_POL];
			O_DIFF2_B_INV <= d2_type == TYPE_CMOS && !regs_ff[IX_POL][B_D2_POL];
			O_DIV4_SRC <= regs_ff[IX_OEC][B_DIV4_SRC];
			O_DIVIDER4_CHAN2_ENABLE <= regs_ff[IX_SE][B_CH2D4] && !pd;
			O_DIVIDER4_CHAN3_ENABLE <= regs_ff[IX_SE][B_CH3D4] && !pd;
			O_PLL2_CH2_EN <= regs_ff[IX_LOOP][B_CH2] && !pd;
			O_PLL2_SPREAD_EN <= regs_ff[IX_PLL2][B_SPREAD];
			O_SE1_LOWFREQ <= !regs_ff[IX_SE][B_SE1_DEF];
			O_SE1_DIV4 <= regs_ff[IX_SE][B_SE1_DEF] && regs_ff[IX_SE][B_SE1_CSEL];
			O_FREQ_SW_EN <= regs_ff[IX_WDG][B_FREQ_SWITCH_ENABLE];
			O_FREQ_SEL <= (role == ROLE_FSEL0) ? {regs_ff[IX_PFS][F_FSEL_LO + 1], pin1_s}
				: regs_ff[IX_PFS][F_FSEL_LO +: 2];
			O_WD_ALARM <= alarm_ff;
		end
	end

	////////////////////////////////////////////////////////////////
	// checks
	property p_gate1;
		(regs_ff[IX_OEC][B_D1_GATE] && !oe2_s) |=> !O_DIFFOUT1_ENABLE;
	endproperty
	a_gate1: assert property (p_gate1) else $error("output 1 not gated by pin");

	property p_diff_en;
		(!regs_ff[IX_OEC][B_D2_EN] ##1 !regs_ff[IX_OEC][B_D2_EN]) |-> !O_DIFFOUT2_ENABLE;
	endproperty
	a_diff_en: assert property (p_diff_en) else $error("output 2 on while disabled");

	property p_pin_pd;
		(role == ROLE_PD_N && !pin1_s) |=> O_CHIP_PD && !O_SINGLE_OUT1_ENABLE && !O_DIFFOUT1_ENABLE;
	endproperty
	a_pin_pd: assert property (p_pin_pd) else $error("pin power-down ignored");

	property p_fsel;
		(role == ROLE_FSEL0) |=> O_FREQ_SEL == {$past(regs_ff[IX_PFS][1]), $past(pin1_s)};
	endproperty
	a_fsel: assert property (p_fsel) else $error("frequency line from pin wrong");

	sequence s_wd_due;
		regs_ff[IX_WDG][B_WATCHDOG_ENABLE] && !wr_stb && wd_cnt_ff == wd_lim;
	endsequence
	property p_wd_fire;
		s_wd_due |=> alarm_ff ##1 O_WD_ALARM;
	endproperty
	a_wd_fire: assert property (p_wd_fire) else $error("watchdog expiry missed");

	property p_wd_early;
		$rose(alarm_ff) |-> $past(wd_cnt_ff) == $past(wd_lim);
	endproperty
	a_wd_early: assert property (p_wd_early) else $error("alarm before timeout");

	property p_alarm_ro;
		(wr_stb && wr_hit && wr_ix == 4'(IX_WDG) && wr_data[B_ALARM] && !alarm_ff && !wd_fire) |=> !alarm_ff;
	endproperty
	a_alarm_ro: assert property (p_alarm_ro) else $error("alarm set by a write");

	property p_hiz;
		(!regs_ff[IX_SE][B_RUN] && regs_ff[IX_POL][B_HIZ]) |=> O_DIFF_HIZ && O_CHIP_PD;
	endproperty
	a_hiz: assert property (p_hiz) else $error("no tristate in power-down");

	property p_rsvd;
		(regs_ff[IX_D1] & ~REG_WMSK[IX_D1]) == (REG_RST[IX_D1] & ~REG_WMSK[IX_D1]);
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits changed");

	property p_run;
		!regs_ff[IX_SE][B_RUN] |=> O_CHIP_PD && !O_DIFFOUT2_ENABLE && !O_DIVIDER4_CHAN2_ENABLE;
	endproperty
	a_run: assert property (p_run) else $error("chip power-down ignored");

	property p_bpin;
		!regs_ff[IX_D1][B_BPIN] |=> !O_DIFF1_B_EN;
	endproperty
	a_bpin: assert property (p_bpin) else $error("B-pin driven while disabled");

	property p_hcsl;
		(d2_type != TYPE_HCSL) |=> !O_DIFF2_HCSL;
	endproperty
	a_hcsl: assert property (p_hcsl) else $error("HCSL mode without its type code");

	property p_se1_src;
		!regs_ff[IX_SE][B_SE1_DEF] |=> O_SE1_LOWFREQ && !O_SE1_DIV4;
	endproperty
	a_se1_src: assert property (p_se1_src) else $error("output 1 not at low-frequency default");

	property p_div4_ch3;
		(!regs_ff[IX_SE][B_CH3D4] || pd) |=> !O_DIVIDER4_CHAN3_ENABLE;
	endproperty
	a_div4_ch3: assert property (p_div4_ch3) else $error("divider 4 channel 3 on while off");

	property p_se1_off;
		!regs_ff[IX_PFS][B_SINGLE_OUT1_ENABLE] |=> !O_SINGLE_OUT1_ENABLE;
	endproperty
	a_se1_off: assert property (p_se1_off) else $error("single-ended output on while disabled");

	property p_pll2_ch2;
		(!regs_ff[IX_LOOP][B_CH2] || pd) |=> !O_PLL2_CH2_EN;
	endproperty
	a_pll2_ch2: assert property (p_pll2_ch2) else $error("PLL2 channel 2 on while disabled");
endmodule // cocr_top
`default_nettype wire

//--- testbench/cocr_i2c_host.sv
`timescale 1ns/100ps
`default_nettype none
module cocr_i2c_host import cocr_pkg::*; (
	input  wire logic i_clk,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_pull
);
	int  nack_cnt = 0;
	time t_mark = 0;
	initial begin
		o_scl = 1'b1;
		o_sda_pull = 1'b0;
	end
	// 8 clocks a phase keeps clear of the 4 clock synchroniser minimum
	task automatic hp();
		repeat (8) @(posedge i_clk);
		#1;
	endtask
	// sda only moves mid-low so no false start or stop is seen
	task automatic bit_io(input logic b, output logic r);
		hp();
		o_sda_pull = ~b;
		hp();
		o_scl = 1'b1;
		hp();
		r = i_sda;
		o_scl = 1'b0;
	endtask
	task automatic byte_io(input logic [7:0] d, input logic nak, output logic [7:0] q);
		logic a;
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		t_mark = $time;
		// ack slot is always released: a write byte must see the slave pull low,
		// a read byte marked nak is closed by the master with the released line
		bit_io(1'b1, a);
		if (!nak && a !== 1'b0) nack_cnt++;
	endtask
	task automatic start();
		hp();
		o_sda_pull = 1'b0;
		hp();
		o_scl = 1'b1;
		hp();
		o_sda_pull = 1'b1;
		hp();
		o_scl = 1'b0;
	endtask
	task automatic stop();
		hp();
		o_sda_pull = 1'b1;
		hp();
		o_scl = 1'b1;
		hp();
		o_sda_pull = 1'b0;
	endtask
	task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d);
		logic [7:0] q;
		start();
		byte_io({dev, 1'b0}, 1'b0, q);
		byte_io(ptr, 1'b0, q);
		byte_io(d, 1'b0, q);
		stop();
	endtask
	// single byte read ends with a nack, as the master must
	task automatic rd(input logic [7:0] ptr, output logic [7:0] q);
		logic [7:0] x;
		start();
		byte_io({I2C_DEV_ADDR, 1'b0}, 1'b0, x);
		byte_io(ptr, 1'b0, x);
		start();
		byte_io({I2C_DEV_ADDR, 1'b1}, 1'b0, x);
		byte_io(8'hff, 1'b1, q);
		stop();
	endtask
endmodule // cocr_i2c_host
`default_nettype wire

//--- testbench/clock_output_control_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none
module clock_output_control_regs_bench import cocr_pkg::*;;
	localparam int WDT [4] = '{1000, 2000, 3000, 4000};
	logic        clk = 1'b0, rst_n = 1'b0, pin1 = 1'b1, oe2 = 1'b1;
	logic        scl, pull, sda, sda_o, sda_oe_n, alarm;
	logic [23:0] outs;
	logic [7:0]  mdl [NREG];
	int          fail_count = 0, n_compared = 0, cyc = 0;
	always #50 clk = ~clk;
	// open drain with pull-up: the slave shows its drive value only while enabled
	assign sda = (sda_oe_n ? 1'b1 : sda_o) & ~pull;
	cocr_i2c_host cocr_i2c_host_i (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));
	cocr_top #(.P_WDT_CYC0(WDT[0]), .P_WDT_CYC1(WDT[1]), .P_WDT_CYC2(WDT[2]), .P_WDT_CYC3(WDT[3])) cocr_top_i (
		.I_CLOCK(clk), .I_RST_N(rst_n), .I_SCL(scl), .I_SDA(sda), .O_SDA_O(sda_o), .O_SDA_OE_N(sda_oe_n),
		.I_CTRL_PIN1(pin1), .I_OE2_PIN(oe2), .O_CHIP_PD(outs[23]), .O_DIFF_HIZ(outs[22]),
		.O_DIFFOUT1_ENABLE(outs[21]), .O_DIFFOUT2_ENABLE(outs[20]), .O_DIFF1_SRC(outs[19]), .O_DIFF2_SRC(outs[18]),
		.O_DIFF1_HCSL(outs[17]), .O_DIFF2_HCSL(outs[16]), .O_DIFF1_B_EN(outs[15]), .O_DIFF2_B_EN(outs[14]),
		.O_DIFF1_B_INV(outs[13]), .O_DIFF2_B_INV(outs[12]), .O_DIV4_SRC(outs[11]), .O_DIVIDER4_CHAN2_ENABLE(outs[10]),
		.O_DIVIDER4_CHAN3_ENABLE(outs[9]), .O_PLL2_CH2_EN(outs[8]), .O_PLL2_SPREAD_EN(outs[7]), .O_SINGLE_OUT1_ENABLE(outs[6]),
		.O_SE1_LOWFREQ(outs[5]), .O_SE1_DIV4(outs[4]), .O_SE1_PWR_SAVE(outs[3]), .O_FREQ_SW_EN(outs[2]),
		.O_FREQ_SEL(outs[1:0]), .O_WD_ALARM(alarm));
	////////////////////////////////////////////////////////////////
	function automatic logic [23:0] expect_outs(logic p1, logic e2);
		logic [7:0] a, b, c, d, w, s;
		logic       pd, c1, h1, c2, h2, d1, d2;
		a = mdl[IX_OEC];
		b = mdl[IX_PFS];
		c = mdl[IX_D1];
		d = mdl[IX_D2];
		w = mdl[IX_POL];
		s = mdl[IX_SE];
		pd = ~s[B_RUN] | (b[6:5] == ROLE_PD_N && !p1);
		c1 = c[5:4] == TYPE_CMOS;
		h1 = c[5:4] == TYPE_HCSL;
		c2 = d[5:4] == TYPE_CMOS;
		h2 = d[5:4] == TYPE_HCSL;
		d1 = a[B_D1_EN] & ~pd & (c1 | h1) & (~a[B_D1_GATE] | e2);
		d2 = a[B_D2_EN] & ~pd & (c2 | h2) & (~a[B_D2_GATE] | e2);
		return {pd, pd & w[B_HIZ], d1, d2, c[7], d[7], d1 & h1, d2 & h2, d1 & c1 & c[0], d2 & c2 & d[0],
			c1 & ~w[B_D1_POL], c2 & ~w[B_D2_POL], a[B_DIV4_SRC], s[0] & ~pd, s[1] & ~pd,
			mdl[IX_LOOP][B_CH2] & ~pd, mdl[IX_PLL2][B_SPREAD], b[7] & ~pd & (b[5] | p1), ~s[4], s[4] & s[3],
			b[6:5] == ROLE_PSAVE && !p1 && !pd, mdl[IX_WDG][B_FREQ_SWITCH_ENABLE], b[6:5] == ROLE_FSEL0 ? {b[1], p1} : b[1:0]};
	endfunction
	function automatic int idx(logic [7:0] ofs);
		for (int i = 0; i < NREG; i++) if (REG_OFS[i] == ofs) return i;
		return -1;
	endfunction
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] ofs, input logic [7:0] v);
		int i;
		i = idx(ofs);
		cocr_i2c_host_i.wr(I2C_DEV_ADDR, ofs, v);
		if (i >= 0) mdl[i] = (v & REG_WMSK[i]) | (mdl[i] & ~REG_WMSK[i]);
	endtask
	task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] e);
		logic [7:0] q;
		cocr_i2c_host_i.rd(ofs, q);
		check({16'h0, q}, {16'h0, e});
	endtask
	// pin terms lag the registers by the synchroniser
	task automatic chk_outs();
		repeat (6) @(posedge clk);
		#1;
		check(outs, expect_outs(pin1, oe2));
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			fail_count++;
			give_verdict();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] v;
		int         k, t;
		for (int i = 0; i < NREG; i++) mdl[i] = REG_RST[i];
		void'($urandom(57613));
		repeat (16) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		check(outs, expect_outs(1'b1, 1'b1));
		for (int i = 0; i < NREG; i++) rd_chk(REG_OFS[i], REG_RST[i]);
		$display("test defaults done");
		wr(8'h30, 8'h5a);
		rd_chk(8'h30, 8'h00);
		wr(8'h20, 8'h01);
		rd_chk(8'h20, 8'h00);
		// a foreign device address is left unanswered and changes nothing
		cocr_i2c_host_i.wr(I2C_DEV_ADDR ^ 7'h01, 8'h1d, 8'h00);
		rd_chk(8'h1d, mdl[IX_OEC]);
		$display("test refusals done");
		for (int r = 0; r < 8; r++) begin
			wr(8'h1e, {1'b1, r[2:1], 3'b000, 2'($urandom)});
			pin1 = r[0];
			chk_outs();
		end
		for (int y = 0; y < 4; y++) begin
			// only the two defined type codes; the reserved ones are the host's to avoid
			wr(8'h22, {1'($urandom), 1'b1, {2{y[0]}}, 2'b01, 1'($urandom), y[1]});
			chk_outs();
		end
		$display("test pin roles and types done");
		wr(8'h1d, 8'he3);
		oe2 = 1'b0;
		chk_outs();
		wr(8'h21, 8'ha4);
		wr(8'h24, 8'h0c);
		chk_outs();
		$display("test gating and power-down done");
		for (int n = 0; n < 16; n++) begin
			k = $urandom_range(NREG - 1);
			v = 8'($urandom);
			if (k == IX_WDG) v[B_WATCHDOG_ENABLE] = 1'b0;
			if (k == IX_D1 || k == IX_D2) v[5] = v[4];
			wr(REG_OFS[k], v);
			pin1 = 1'($urandom);
			oe2 = 1'($urandom);
			chk_outs();
			rd_chk(REG_OFS[k], mdl[k]);
		end
		$display("test random settings done");
		rst_n = 1'b0;
		repeat (16) @(posedge clk);
		#1 rst_n = 1'b1;
		for (int i = 0; i < NREG; i++) mdl[i] = REG_RST[i];
		repeat (4) @(posedge clk);
		#1;
		check(outs, expect_outs(pin1, oe2));
		rd_chk(8'h24, REG_RST[IX_SE]);
		$display("test mid-run reset done");
		wr(8'h24, 8'h8c);
		for (int s = 0; s < 4; s++) begin
			wr(8'h20, {4'h0, 1'b1, s[1:0], 1'b0});
			t = 0;
			while (alarm !== 1'b1 && t < 6000) begin
				@(posedge clk);
				#1;
				t++;
			end
			t = int'(($time - cocr_i2c_host_i.t_mark) / 100);
			check({23'h0, t >= WDT[s] && t <= WDT[s] + 12}, 24'h1);
			rd_chk(8'h20, {4'h0, 1'b1, s[1:0], 1'b1});
			wr(8'h20, 8'h00);
			check({23'h0, alarm}, 24'h0);
		end
		// only the three bytes sent to the foreign address go unanswered
		check(24'(cocr_i2c_host_i.nack_cnt), 24'h3);
		$display("test watchdog done");
		give_verdict();
	end
endmodule // clock_output_control_regs_bench
`default_nettype wire
